// >>> src/output_driver_pkg.sv
// constants, register map and types for the output driver state control
package output_driver_pkg;

    localparam int NUM_CLK     = 10;
    localparam int NUM_REF     = 8;
    localparam int NUM_CHAN    = 5;
    localparam int ADDR_W      = 8;
    localparam int NUM_CFG     = 13;

    // byte offsets of the register words
    localparam logic [7:0] CLK_POWER_OFF_OFS  = 8'h00;
    localparam logic [7:0] CLK_ENABLE_OFS     = 8'h04;
    localparam logic [7:0] CLK_STYLE_OFS      = 8'h08;
    localparam logic [7:0] CLK_AMPLITUDE_OFS  = 8'h0C;
    localparam logic [7:0] CHAN_POWER_OFF_OFS = 8'h10;
    localparam logic [7:0] REF_FUNC_OFS       = 8'h14;
    localparam logic [7:0] REF_POWER_OFF_OFS  = 8'h18;
    localparam logic [7:0] REF_ENABLE_OFS     = 8'h1C;
    localparam logic [7:0] REF_STYLE_OFS      = 8'h20;
    localparam logic [7:0] REF_AMPLITUDE_OFS  = 8'h24;
    localparam logic [7:0] REF_IDLE_BIAS_OFS  = 8'h28;
    localparam logic [7:0] EVENT_CTRL_OFS     = 8'h2C;
    localparam logic [7:0] OSC_CTRL_OFS       = 8'h30;
    localparam logic [7:0] EVENT_STATUS_OFS   = 8'h34;
    localparam logic [7:0] CLK_STATE_OFS      = 8'h38;
    localparam logic [7:0] REF_STATE_OFS      = 8'h3C;

    // word indices of the stored configuration words
    localparam int IDX_CLK_POWER_OFF  = 0;
    localparam int IDX_CLK_ENABLE     = 1;
    localparam int IDX_CLK_STYLE      = 2;
    localparam int IDX_CLK_AMPLITUDE  = 3;
    localparam int IDX_CHAN_POWER_OFF = 4;
    localparam int IDX_REF_FUNC       = 5;
    localparam int IDX_REF_POWER_OFF  = 6;
    localparam int IDX_REF_ENABLE     = 7;
    localparam int IDX_REF_STYLE      = 8;
    localparam int IDX_REF_AMPLITUDE  = 9;
    localparam int IDX_REF_IDLE_BIAS  = 10;
    localparam int IDX_EVENT_CTRL     = 11;
    localparam int IDX_OSC_CTRL       = 12;

    // fields of the event control and oscillator words
    localparam int EV_COUNT_LSB      = 0;
    localparam int EV_CONTINUOUS_BIT = 8;
    localparam int EV_BIAS_TYPE_BIT  = 9;
    localparam int EV_START_BIT      = 16;
    localparam int OSC_POWER_ON_BIT  = 0;
    localparam int OSC_STYLE_BIT     = 1;
    localparam int OSC_AMPLITUDE_LSB = 2;

    localparam logic [31:0] CFG_MASK [0:NUM_CFG-1] = '{
        32'h0000_03FF, 32'h0000_03FF, 32'h0000_03FF, 32'h000F_FFFF,
        32'h0000_001F, 32'h0000_00FF, 32'h0000_00FF, 32'h0000_00FF,
        32'h0000_00FF, 32'h0000_FFFF, 32'h0000_00FF, 32'h0000_03FF,
        32'h0000_000F};
    localparam logic [31:0] CFG_RESET [0:NUM_CFG-1] = '{
        32'h0000_03FF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000,
        32'h0000_0000, 32'h0000_5555, 32'h0000_0000, 32'h0000_0001,
        32'h0000_0000};

    // channel of each output: A0 A1 A2 B0 B1 C0 C1 D E0 E1
    localparam logic [2:0] CLK_CHANNEL [0:NUM_CLK-1] = '{
        3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4};
    localparam logic [2:0] REF_CHANNEL [0:NUM_REF-1] = '{
        3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3};

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // driver state reported per output
    typedef enum logic [1:0] {
        DRV_OFF    = 2'h0,
        DRV_LOW    = 2'h1,
        DRV_SWITCH = 2'h2,
        DRV_BIAS   = 2'h3
    } drive_state_t;

    // swing codes: 0 = 250, 1 = 500, 2 = 750, 3 = 1000 millivolts
    localparam logic [1:0] SWING_250 = 2'h0;
    localparam logic [1:0] SWING_500 = 2'h1;
    localparam logic [1:0] SWING_750 = 2'h2;

    typedef enum logic [1:0] {
        EV_IDLE = 2'h0,
        EV_RUN  = 2'h1,
        EV_DONE = 2'h3
    } event_state_t;

endpackage

// >>> src/output_driver_state_control.sv
// output driver state control with frame-reference event sequencing
// Function
// - power-off bit turns clock output off
// - powered, disabled clock output held static low
// - amplitude code selects 250 to 1000 mV
// - power-off per output, and per channel for clock outputs and frame-mode reference outputs
// - every clock and reference output has enable
// - frame mode: event machine sets reference state
// - frame output: off, low, or 500 mV switching; the swing here follows the reference amplitude word (500 mV code at reset)
// - idle bias drives line-bias state when powered
// - event start turns frame outputs on
// - event completion returns frame outputs to rest state
// - idle bias biases idle outputs to midpoint
// - line bias only for low-voltage differential style
// - bias type 0: rest low, switch, low
// - bias type 1: rest crosspoint, switch, crosspoint
// - idle bias keeps output static during event
// - oscillator output power, three-step amplitude
// - function select: clock copy or frame reference
// - counted event pulses programmable 1 to 255
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module output_driver_state_control (
    input  wire logic                                  aclk,
    input  wire logic                                  aresetn,
    input  wire logic [output_driver_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                                  s_axi_awvalid,
    output var  logic                                  s_axi_awready,
    input  wire logic [31:0]                           s_axi_wdata,
    input  wire logic [3:0]                            s_axi_wstrb,
    input  wire logic                                  s_axi_wvalid,
    output var  logic                                  s_axi_wready,
    output var  logic [1:0]                            s_axi_bresp,
    output var  logic                                  s_axi_bvalid,
    input  wire logic                                  s_axi_bready,
    input  wire logic [output_driver_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                                  s_axi_arvalid,
    output var  logic                                  s_axi_arready,
    output var  logic [31:0]                           s_axi_rdata,
    output var  logic [1:0]                            s_axi_rresp,
    output var  logic                                  s_axi_rvalid,
    input  wire logic                                  s_axi_rready,
    input  wire logic                                  ext_event_trigger,
    input  wire logic                                  frame_pulse_tick,
    output var  logic [2*output_driver_pkg::NUM_CLK-1:0] clock_output_state,
    output var  logic [2*output_driver_pkg::NUM_CLK-1:0] clock_output_swing,
    output var  logic [2*output_driver_pkg::NUM_REF-1:0] reference_output_state,
    output var  logic [2*output_driver_pkg::NUM_REF-1:0] reference_output_swing,
    output var  logic [1:0]                            oscillator_monitor_output_state,
    output var  logic [1:0]                            oscillator_monitor_output_swing,
    output var  logic                                  frame_event_active
);
    import output_driver_pkg::*;

    logic [31:0]          cfg [0:NUM_CFG-1];
    logic [ADDR_W-1:0]    wr_addr;
    logic [31:0]          wr_data;
    logic [3:0]           wr_strb;

    logic                 ext_sync_a;
    logic                 ext_sync_b;
    logic                 ext_sync_prev;

    event_state_t         ev_state;
    event_state_t         next_ev_state;
    logic [7:0]           ev_remaining;
    logic [7:0]           next_ev_remaining;
    logic                 ev_continuous;

    // register bus decode
    wire                  do_write     = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire  [5:0]           wr_index     = wr_addr[7:2];
    wire  [5:0]           rd_index     = s_axi_araddr[7:2];

    wire  [31:0]          byte_mask    = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire                  wr_mapped    = (wr_addr[1:0] == 2'h0) && (wr_index <= REF_STATE_OFS[7:2]);
    wire                  rd_mapped    = (s_axi_araddr[1:0] == 2'h0) && (rd_index <= REF_STATE_OFS[7:2]);

    // event trigger and control
    wire                  ext_edge     = ext_sync_b && !ext_sync_prev;
    wire                  sw_start     = do_write && (wr_addr == EVENT_CTRL_OFS) && wr_strb[2]
                                         && wr_data[EV_START_BIT];
    wire                  start_req    = sw_start || ext_edge;
    // a start write brings its own count and mode
    wire  [7:0]           cfg_count    = (sw_start && wr_strb[0]) ? wr_data[EV_COUNT_LSB +: 8]
                                         : cfg[IDX_EVENT_CTRL][EV_COUNT_LSB +: 8];
    wire  [7:0]           load_count   = (cfg_count == 8'h00) ? 8'h01 : cfg_count;
    wire                  cfg_cont     = (sw_start && wr_strb[1]) ? wr_data[EV_CONTINUOUS_BIT]
                                         : cfg[IDX_EVENT_CTRL][EV_CONTINUOUS_BIT];
    wire                  bias_type    = cfg[IDX_EVENT_CTRL][EV_BIAS_TYPE_BIT];
    wire                  ev_running   = (ev_state == EV_RUN);

    // read data selection
    wire  [31:0]          status_word  = {14'h0000, ev_state, ev_remaining, 7'h00, ev_running};
    wire  [31:0]          rd_word      = !rd_mapped ? 32'h0000_0000 :
                                         (s_axi_araddr == EVENT_STATUS_OFS) ? status_word :
                                         (s_axi_araddr == CLK_STATE_OFS) ? {12'h000, clock_output_state} :
                                         (s_axi_araddr == REF_STATE_OFS) ? {16'h0000, reference_output_state} :
                                         cfg[rd_index[3:0]];

    // oscillator monitor decode
    wire  [1:0]           osc_amp      = cfg[IDX_OSC_CTRL][OSC_AMPLITUDE_LSB +: 2];
    wire  [1:0]           osc_swing    = (osc_amp == 2'h0) ? SWING_250 :
                                         (osc_amp == 2'h3) ? SWING_750 : SWING_500;
    wire  drive_state_t   osc_state    = cfg[IDX_OSC_CTRL][OSC_POWER_ON_BIT] ? DRV_SWITCH : DRV_OFF;

    // write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            wr_addr       <= '0;
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end

            if (s_axi_wvalid && s_axi_wready) begin
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end

            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end

            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // configuration words, applied live without reset
    generate
        for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
            wire [31:0] keep_mask = byte_mask & CFG_MASK[i];
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cfg[i] <= CFG_RESET[i];
                end else if (do_write && wr_mapped && (wr_index == 6'(i))) begin
                    cfg[i] <= (cfg[i] & ~keep_mask) | (wr_data & keep_mask);
                end
            end
        end
    endgenerate

    // external trigger synchroniser and edge history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync_a    <= 1'b0;
            ext_sync_b    <= 1'b0;
            ext_sync_prev <= 1'b0;
        end else begin
            ext_sync_a    <= ext_event_trigger;
            ext_sync_b    <= ext_sync_a;
            ext_sync_prev <= ext_sync_b;
        end
    end

    // frame-reference event sequencer
    always_comb begin
        next_ev_state     = ev_state;
        next_ev_remaining = ev_remaining;
        unique case (ev_state)
            EV_IDLE: begin
                if (start_req) begin
                    next_ev_state     = EV_RUN;
                    next_ev_remaining = load_count;
                end
            end

            EV_RUN: begin
                if (ev_continuous) begin
                    if (!cfg_cont) begin
                        next_ev_state = EV_DONE;
                    end
                end else if (frame_pulse_tick) begin
                    next_ev_remaining = ev_remaining - 8'h01;
                    if (ev_remaining == 8'h01) begin
                        next_ev_state = EV_DONE;
                    end
                end
            end

            EV_DONE: begin
                next_ev_state = EV_IDLE;
            end
            default: begin
                next_ev_state = EV_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_state           <= EV_IDLE;
            ev_remaining       <= 8'h00;
            ev_continuous      <= 1'b0;
            frame_event_active <= 1'b0;
        end else begin
            ev_state           <= next_ev_state;
            ev_remaining       <= next_ev_remaining;
            frame_event_active <= (next_ev_state == EV_RUN);

            if (ev_state == EV_IDLE) begin
                ev_continuous <= cfg_cont;
            end
        end
    end

    // clock outputs
    generate
        for (genvar i = 0; i < NUM_CLK; i++) begin : g_clk
            wire          off  = cfg[IDX_CLK_POWER_OFF][i] || cfg[IDX_CHAN_POWER_OFF][CLK_CHANNEL[i]];
            wire          en   = cfg[IDX_CLK_ENABLE][i];
            wire drive_state_t next_state = off ? DRV_OFF : (en ? DRV_SWITCH : DRV_LOW);
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    clock_output_state[2*i +: 2] <= DRV_OFF;
                    clock_output_swing[2*i +: 2] <= SWING_250;
                end else begin
                    clock_output_state[2*i +: 2] <= next_state;
                    clock_output_swing[2*i +: 2] <= cfg[IDX_CLK_AMPLITUDE][2*i +: 2];
                end
            end
        end
    endgenerate

    // reference outputs, clock copy or frame reference
    generate
        for (genvar r = 0; r < NUM_REF; r++) begin : g_ref
            wire          frame    = cfg[IDX_REF_FUNC][r];
            wire          out_off  = cfg[IDX_REF_POWER_OFF][r];
            wire          chan_off = cfg[IDX_CHAN_POWER_OFF][REF_CHANNEL[r]];
            wire          en       = cfg[IDX_REF_ENABLE][r];
            wire          idle_line_bias = cfg[IDX_REF_IDLE_BIAS][r];

            wire          bias_ok  = !cfg[IDX_REF_STYLE][r] && bias_type;
            wire drive_state_t rest_state = bias_ok ? DRV_BIAS : DRV_LOW;
            wire drive_state_t clock_state = out_off ? DRV_OFF : (en ? DRV_SWITCH : DRV_LOW);
            wire drive_state_t frame_state = (out_off || chan_off) ? DRV_OFF :
                                             idle_line_bias ? rest_state :
                                             !en ? DRV_LOW :
                                             ev_running ? DRV_SWITCH : rest_state;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    reference_output_state[2*r +: 2] <= DRV_OFF;
                    reference_output_swing[2*r +: 2] <= SWING_500;
                end else begin
                    reference_output_state[2*r +: 2] <= frame ? frame_state : clock_state;
                    reference_output_swing[2*r +: 2] <= cfg[IDX_REF_AMPLITUDE][2*r +: 2];
                end
            end
        end
    endgenerate

    // oscillator monitor output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oscillator_monitor_output_state <= DRV_OFF;
            oscillator_monitor_output_swing <= SWING_250;
        end else begin
            oscillator_monitor_output_state <= osc_state;
            oscillator_monitor_output_swing <= osc_swing;
        end
    end

endmodule

`default_nettype wire

// >>> bench/output_driver_asserts.sv
// checker of bus handshakes, event start and output states
`timescale 1ns/100ps
`default_nettype none
module output_driver_asserts (
    input wire logic                                    aclk,
    input wire logic                                    aresetn,
    input wire logic                                    s_axi_awvalid,
    input wire logic                                    s_axi_awready,
    input wire logic                                    s_axi_wvalid,
    input wire logic                                    s_axi_wready,
    input wire logic [1:0]                              s_axi_bresp,
    input wire logic                                    s_axi_bvalid,
    input wire logic                                    s_axi_bready,
    input wire logic                                    s_axi_arvalid,
    input wire logic                                    s_axi_arready,
    input wire logic [31:0]                             s_axi_rdata,
    input wire logic                                    s_axi_rvalid,
    input wire logic                                    s_axi_rready,
    input wire logic                                    ext_event_trigger,
    input wire logic [2*output_driver_pkg::NUM_CLK-1:0] clock_output_state,
    input wire logic [1:0]                              oscillator_monitor_output_state,
    input wire logic [1:0]                              oscillator_monitor_output_swing,
    input wire logic                                    frame_event_active
);
    import output_driver_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_write_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response late");
    property p_read_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_resp: assert property (p_read_resp) else $error("read response late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    property p_aw_block;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready until (s_axi_bvalid && s_axi_bready);
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken early");
    property p_clk_no_bias;
        ~|(clock_output_state & (clock_output_state >> 1) & {NUM_CLK{2'b01}});
    endproperty
    a_clk_no_bias: assert property (p_clk_no_bias) else $error("clock output biased");
    property p_osc_codes;
        oscillator_monitor_output_state[0] == 1'b0 && oscillator_monitor_output_swing != 2'h3;
    endproperty
    a_osc_codes: assert property (p_osc_codes) else $error("oscillator code illegal");
    property p_ext_start;
        $rose(ext_event_trigger) && !frame_event_active && !$past(frame_event_active)
            |-> ##[3:5] frame_event_active;
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("event did not start");
endmodule
bind output_driver_state_control output_driver_asserts u_asserts (.*);
`default_nettype wire

// >>> bench/converter_ref_sink.sv
// converter side model: frame pulse source and pulse counter
`timescale 1ns/100ps
`default_nettype none
module converter_ref_sink (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       tick_en,
    input  wire logic [3:0] tick_gap,
    input  wire logic       frame_event_active,
    output var  logic       frame_pulse_tick,
    output var  logic [8:0] pulses_seen
);
    logic [3:0] gap_cnt;
    logic       active_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_cnt <= 4'h0;
            frame_pulse_tick <= 1'b0;
            active_q <= 1'b0;
            pulses_seen <= 9'h000;
        end else begin
            gap_cnt <= (gap_cnt >= tick_gap) ? 4'h0 : gap_cnt + 4'h1;
            frame_pulse_tick <= tick_en && (gap_cnt >= tick_gap);
            active_q <= frame_event_active;
            if (frame_event_active && !active_q) begin
                pulses_seen <= {8'h00, frame_pulse_tick};
            end else if (frame_event_active && frame_pulse_tick) begin
                pulses_seen <= pulses_seen + 9'h001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_output_driver_state_control.sv
// testbench for the output driver state control
`timescale 1ns/100ps
`default_nettype none
module tb_output_driver_state_control;
    import output_driver_pkg::*;
    typedef struct {logic [7:0] ofs; logic [31:0] data; int kind; drive_state_t st; logic [1:0] sw;} row_t;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, ext_trig, tick, active, tick_en;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, osc_st, osc_sw;
    logic [19:0] clk_st, clk_sw;
    logic [15:0] ref_st, ref_sw;
    logic [3:0]  tick_gap;
    logic [8:0]  pulses;
    int          mismatches, samples_checked;
    row_t rows [24] = '{
        '{CLK_ENABLE_OFS, 32'h1, 0, DRV_OFF, 2'h0}, '{CLK_POWER_OFF_OFS, 32'h0, 0, DRV_SWITCH, 2'h0},
        '{CLK_AMPLITUDE_OFS, 32'hB, 0, DRV_SWITCH, 2'h3}, '{CLK_STYLE_OFS, 32'h2, 1, DRV_LOW, 2'h2},
        '{CHAN_POWER_OFF_OFS, 32'h1, 0, DRV_OFF, 2'h3}, '{CHAN_POWER_OFF_OFS, 32'h0, 0, DRV_SWITCH, 2'h3},
        '{CLK_ENABLE_OFS, 32'h2, 1, DRV_SWITCH, 2'h2}, '{CLK_AMPLITUDE_OFS, 32'h4, 1, DRV_SWITCH, 2'h1},
        '{REF_ENABLE_OFS, 32'h1, 2, DRV_OFF, 2'h1}, '{REF_POWER_OFF_OFS, 32'h0, 2, DRV_SWITCH, 2'h1},
        '{REF_FUNC_OFS, 32'h1, 2, DRV_LOW, 2'h1}, '{EVENT_CTRL_OFS, 32'h201, 2, DRV_BIAS, 2'h1},
        '{REF_IDLE_BIAS_OFS, 32'h1, 2, DRV_BIAS, 2'h1}, '{REF_STYLE_OFS, 32'h1, 2, DRV_LOW, 2'h1},
        '{REF_STYLE_OFS, 32'h0, 2, DRV_BIAS, 2'h1}, '{CHAN_POWER_OFF_OFS, 32'h1, 2, DRV_OFF, 2'h1},
        '{CHAN_POWER_OFF_OFS, 32'h0, 2, DRV_BIAS, 2'h1}, '{REF_IDLE_BIAS_OFS, 32'h0, 2, DRV_BIAS, 2'h1},
        '{EVENT_CTRL_OFS, 32'h1, 2, DRV_LOW, 2'h1}, '{OSC_CTRL_OFS, 32'h1, 3, DRV_SWITCH, 2'h0},
        '{OSC_CTRL_OFS, 32'h5, 3, DRV_SWITCH, 2'h1}, '{OSC_CTRL_OFS, 32'h9, 3, DRV_SWITCH, 2'h1},
        '{OSC_CTRL_OFS, 32'hF, 3, DRV_SWITCH, 2'h2}, '{OSC_CTRL_OFS, 32'hE, 3, DRV_OFF, 2'h2}};
    output_driver_state_control dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_event_trigger(ext_trig),
        .frame_pulse_tick(tick), .clock_output_state(clk_st), .clock_output_swing(clk_sw),
        .reference_output_state(ref_st), .reference_output_swing(ref_sw), .oscillator_monitor_output_state(osc_st),
        .oscillator_monitor_output_swing(osc_sw), .frame_event_active(active));
    converter_ref_sink u_sink (.aclk(aclk), .aresetn(aresetn), .tick_en(tick_en), .tick_gap(tick_gap),
        .frame_event_active(active), .frame_pulse_tick(tick), .pulses_seen(pulses));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        cmp(32'(bresp), 32'(er));
    endtask
    task automatic axi_read(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        cmp(rdata, exp);
        cmp(32'(rresp), 32'(er));
    endtask
    task automatic run_event(input logic ext, input logic [7:0] n, input logic [3:0] gap, input drive_state_t mid);
        tick_gap <= gap;
        axi_write(EVENT_CTRL_OFS, {15'h0, !ext, 8'h0, n}, RESP_OKAY);
        ext_trig <= ext;
        while (active !== 1'b1) @(posedge aclk);
        repeat (2) @(posedge aclk);
        cmp(32'(ref_st[1:0]), 32'(mid));
        tick_en <= 1'b1;
        while (active !== 1'b0) @(posedge aclk);
        repeat (2) @(posedge aclk);
        cmp(32'(ref_st[1:0]), 32'(DRV_LOW));
        cmp(32'(pulses), 32'(n));
        tick_en <= 1'b0;
        ext_trig <= 1'b0;
        $display("event test done");
    endtask
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_trig, tick_en} = 8'h00;
        {awaddr, araddr, wdata, tick_gap} = 52'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            axi_write(rows[i].ofs, rows[i].data, RESP_OKAY);
            repeat (2) @(posedge aclk);
            case (rows[i].kind)
                0: cmp({28'h0, clk_sw[1:0], clk_st[1:0]}, {28'h0, rows[i].sw, rows[i].st});
                1: cmp({28'h0, clk_sw[3:2], clk_st[3:2]}, {28'h0, rows[i].sw, rows[i].st});
                2: cmp({28'h0, ref_sw[1:0], ref_st[1:0]}, {28'h0, rows[i].sw, rows[i].st});
                default: cmp({28'h0, osc_sw, osc_st}, {28'h0, rows[i].sw, rows[i].st});
            endcase
        end
        $display("table test done");
        axi_write(REF_AMPLITUDE_OFS, 32'h0000_5555, RESP_OKAY);
        run_event(1'b0, 8'h02, 4'h3, DRV_SWITCH);
        axi_write(REF_IDLE_BIAS_OFS, 32'h0000_0001, RESP_OKAY);
        run_event(1'b1, 8'h02, 4'h1, DRV_LOW);
        axi_write(REF_IDLE_BIAS_OFS, 32'h0000_0000, RESP_OKAY);
        run_event(1'b0, 8'hFF, 4'h1, DRV_SWITCH);
        tick_en <= 1'b1;
        repeat (20) @(posedge aclk);
        cmp(32'(active), 32'h0000_0000);
        tick_en <= 1'b0;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        cmp({clk_st, ref_sw[15:4]}, 32'h0000_0555);
        aresetn <= 1'b1;
        axi_read(CLK_POWER_OFF_OFS, 32'h0000_03FF, RESP_OKAY);
        axi_read(EVENT_CTRL_OFS, 32'h0000_0001, RESP_OKAY);
        axi_write(CHAN_POWER_OFF_OFS, 32'hFFFF_FFFF, RESP_OKAY);
        axi_read(CHAN_POWER_OFF_OFS, 32'h0000_001F, RESP_OKAY);
        axi_write(8'h40, 32'h0000_0001, RESP_SLVERR);
        axi_write(8'h02, 32'h0000_0001, RESP_SLVERR);
        axi_read(8'h40, 32'h0000_0000, RESP_SLVERR);
        $display("reset and bus test done");
        print_verdict();
    end
endmodule
`default_nettype wire
